// file: rtl/pmx_port_mux.sv
// Top of the port mode pin multiplexer.
`timescale 1ns/1ns
`include "pmx_params.svh"
module pmx_port_mux
(
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Mode select pins, sampled while reset is held.
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  // Core bus request in expanded modes.
  input wire logic bus_phase_clock,
  input wire logic [15:0] core_addr,
  input wire logic core_read,
  input wire logic [7:0] core_wdata,
  output logic [7:0] core_rdata,
  // Core port B and port C controls for single-chip modes.
  input wire logic [7:0] gp_port_b_out,
  input wire logic [7:0] gp_port_c_out,
  input wire logic [7:0] gp_port_c_dir,
  input wire logic strobe_rising,
  input wire logic handshake_out_level,
  output logic [7:0] port_c_in_value,
  output logic [7:0] port_c_latched,
  output logic latch_event,
  // Port B pins.
  output logic [7:0] port_b_out,
  // Port C pins as input, output and enable.
  input wire logic [7:0] port_c_lines_in,
  output logic [7:0] port_c_lines_out,
  output logic [7:0] port_c_lines_oe,
  // Strobe pins.
  input wire logic handshake_strobe_in,
  output logic strobe_b_out,
  output logic address_latch_strobe,
  output logic address_latch_strobe_oe,
  // Port D general-purpose controls and serial units.
  input wire logic [5:0] gp_port_d_out,
  input wire logic [5:0] gp_port_d_dir,
  output logic [5:0] port_d_in_value,
  input wire logic serial_enable,
  input wire logic spi_enable,
  input wire logic spi_master,
  input wire logic serial_transmit_out,
  output logic serial_receive_in,
  input wire logic spi_miso_out,
  input wire logic spi_mosi_out,
  input wire logic spi_sck_out,
  output logic spi_miso_in,
  output logic spi_mosi_in,
  output logic spi_sck_in,
  output logic spi_select_in,
  // Port D pins.
  input wire logic [5:0] port_d_in,
  output logic [5:0] port_d_out,
  output logic [5:0] port_d_oe,
  // Port E pins, input only.
  input wire logic [7:0] port_e_in,
  output logic [7:0] port_e_value,
  output logic [7:0] analog_channel,
  // Current mode.
  output pmx_pkg::pmx_mode_t mode
);
  //------------------------------------------------------------
  // Mode capture
  //------------------------------------------------------------
  pmx_pkg::pmx_mode_t mode_q;
  logic expanded;
  logic strobe_edge;

  // Mode pins are followed while reset holds and frozen once it lifts.
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      case ({mode_select_high, mode_select_low})
        `PMX_PAT_SINGLE: mode_q <= pmx_pkg::PMX_SINGLE;
        `PMX_PAT_EXPANDED: mode_q <= pmx_pkg::PMX_EXPANDED;
        `PMX_PAT_BOOT: mode_q <= pmx_pkg::PMX_BOOT;
        `PMX_PAT_TEST: mode_q <= pmx_pkg::PMX_TEST;
        default: mode_q <= pmx_pkg::PMX_SINGLE;
      endcase
    end
  end

  // Test follows expanded and bootstrap follows single-chip.
  assign expanded = (mode_q == pmx_pkg::PMX_EXPANDED) || (mode_q == pmx_pkg::PMX_TEST);

  //------------------------------------------------------------
  // Ports B and C and strobes
  //------------------------------------------------------------
  pmx_edge_det u_edge
  (
    .clock(clock),
    .resetn(resetn),
    .level_in(handshake_strobe_in),
    .rising_sel(strobe_rising),
    .edge_pulse(strobe_edge)
  );

  // Pin drive, registered so each output comes from a flip-flop.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      port_b_out <= 8'h00;
      port_c_lines_out <= 8'h00;
      port_c_lines_oe <= 8'h00;
      strobe_b_out <= 1'b0;
      address_latch_strobe <= 1'b0;
      address_latch_strobe_oe <= 1'b0;
    end
    else if (expanded)
    begin
      // Address on port B always; port C carries address while the phase clock is low.
      port_b_out <= core_addr[15:8];
      strobe_b_out <= core_read;
      address_latch_strobe_oe <= 1'b1;
      address_latch_strobe <= ~bus_phase_clock;
      if (!bus_phase_clock)
      begin
        port_c_lines_out <= core_addr[7:0];
        port_c_lines_oe <= 8'hFF;
      end
      else
      begin
        // Data phase: drive on write, release on read.
        port_c_lines_out <= core_wdata;
        port_c_lines_oe <= core_read ? 8'h00 : 8'hFF;
      end
    end
    else
    begin
      port_b_out <= gp_port_b_out;
      port_c_lines_out <= gp_port_c_out;
      port_c_lines_oe <= gp_port_c_dir;
      strobe_b_out <= handshake_out_level;
      address_latch_strobe <= 1'b0;
      address_latch_strobe_oe <= 1'b0;
    end
  end

  // Port C levels, read data and the strobe-latched byte.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      port_c_in_value <= 8'h00;
      core_rdata <= 8'h00;
      port_c_latched <= `PMX_LATCH_RST;
      latch_event <= 1'b0;
    end
    else
    begin
      port_c_in_value <= port_c_lines_in;
      core_rdata <= (expanded && bus_phase_clock && core_read) ? port_c_lines_in : core_rdata;
      latch_event <= !expanded && strobe_edge;
      if (!expanded && strobe_edge)
      begin
        port_c_latched <= port_c_lines_in;
      end
    end
  end

  //------------------------------------------------------------
  // Port D
  //------------------------------------------------------------
  // Serial units override general-purpose use bit by bit.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      port_d_out <= 6'h00;
      port_d_oe <= 6'h00;
      port_d_in_value <= 6'h00;
      serial_receive_in <= 1'b1;
      spi_miso_in <= 1'b0;
      spi_mosi_in <= 1'b0;
      spi_sck_in <= 1'b0;
      spi_select_in <= 1'b1;
    end
    else
    begin
      port_d_out <= gp_port_d_out;
      port_d_oe <= gp_port_d_dir;
      port_d_in_value <= port_d_in;
      serial_receive_in <= port_d_in[`PMX_PD_RXD];
      spi_miso_in <= port_d_in[`PMX_PD_MISO];
      spi_mosi_in <= port_d_in[`PMX_PD_MOSI];
      spi_sck_in <= port_d_in[`PMX_PD_SCK];
      spi_select_in <= port_d_in[`PMX_PD_SS];
      if (serial_enable)
      begin
        port_d_oe[`PMX_PD_RXD] <= 1'b0;
        port_d_out[`PMX_PD_TXD] <= serial_transmit_out;
        port_d_oe[`PMX_PD_TXD] <= 1'b1;
      end
      if (spi_enable)
      begin
        // Master drives MOSI and SCK; slave drives MISO; select is always input.
        port_d_out[`PMX_PD_MISO] <= spi_miso_out;
        port_d_oe[`PMX_PD_MISO] <= ~spi_master;
        port_d_out[`PMX_PD_MOSI] <= spi_mosi_out;
        port_d_oe[`PMX_PD_MOSI] <= spi_master;
        port_d_out[`PMX_PD_SCK] <= spi_sck_out;
        port_d_oe[`PMX_PD_SCK] <= spi_master;
        port_d_oe[`PMX_PD_SS] <= 1'b0;
      end
    end
  end

  //------------------------------------------------------------
  // Port E and mode output
  //------------------------------------------------------------
  // Port E has no drivers; the same level feeds digital reads and the converter.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      port_e_value <= 8'h00;
      analog_channel <= 8'h00;
      mode <= pmx_pkg::PMX_SINGLE;
    end
    else
    begin
      port_e_value <= port_e_in;
      analog_channel <= port_e_in;
      mode <= mode_q;
    end
  end

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  // Every pin output is registered, so each check but chk_mode_frozen looks one edge after its trigger.
  chk_read_release: assert property (@(posedge clock) disable iff (!resetn)
    (expanded && bus_phase_clock && core_read) |=> (port_c_lines_oe == 8'h00))
    else $error("Port C driven in read data phase.");
  chk_addr_phase: assert property (@(posedge clock) disable iff (!resetn)
    (expanded && !bus_phase_clock) |=> (port_c_lines_out == $past(core_addr[7:0]) && port_c_lines_oe == 8'hFF))
    else $error("Low address missing in address phase.");
  chk_high_addr: assert property (@(posedge clock) disable iff (!resetn)
    expanded |=> (port_b_out == $past(core_addr[15:8])))
    else $error("High address wrong on port B.");
  chk_direction: assert property (@(posedge clock) disable iff (!resetn)
    expanded |=> (strobe_b_out == $past(core_read)))
    else $error("Bus direction mismatch.");
  chk_latch_strobe: assert property (@(posedge clock) disable iff (!resetn)
    expanded |=> (address_latch_strobe_oe && address_latch_strobe == !$past(bus_phase_clock)))
    else $error("Address latch strobe wrong.");
  chk_strobe_latch: assert property (@(posedge clock) disable iff (!resetn)
    (!expanded && strobe_edge) |=> (port_c_latched == $past(port_c_lines_in) && latch_event))
    else $error("Port C not latched on strobe.");
  chk_single_gpio: assert property (@(posedge clock) disable iff (!resetn)
    !expanded |=> (port_c_lines_oe == $past(gp_port_c_dir) && !address_latch_strobe_oe))
    else $error("Single-chip port C not general purpose.");
  chk_serial_tx: assert property (@(posedge clock) disable iff (!resetn)
    serial_enable |=> (port_d_oe[1] && port_d_out[1] == $past(serial_transmit_out)))
    else $error("Transmit pin not handed over.");
  chk_spi_select: assert property (@(posedge clock) disable iff (!resetn)
    spi_enable |=> !port_d_oe[5])
    else $error("Slave select driven.");
  chk_port_e: assert property (@(posedge clock) disable iff (!resetn)
    1'b1 |=> (port_e_value == $past(port_e_in)))
    else $error("Port E value stale.");
  // The mode must not move once reset has lifted, whatever the mode pins do.
  chk_mode_frozen: assert property (@(posedge clock) disable iff (!resetn)
    $past(resetn) |-> $stable(mode_q))
    else $error("Mode changed after reset.");
  chk_read_capture: assert property (@(posedge clock) disable iff (!resetn)
    (expanded && bus_phase_clock && core_read)
    |=> (core_rdata == $past(port_c_lines_in)))
    else $error("Read data not captured.");
  chk_write_data: assert property (@(posedge clock) disable iff (!resetn)
    (expanded && bus_phase_clock && !core_read)
    |=> (port_c_lines_out == $past(core_wdata) && port_c_lines_oe == 8'hFF))
    else $error("Write data missing in data phase.");
  chk_single_port_b: assert property (@(posedge clock) disable iff (!resetn)
    !expanded
    |=> (port_b_out == $past(gp_port_b_out) && strobe_b_out == $past(handshake_out_level)))
    else $error("Single-chip port B or strobe wrong.");
  chk_port_d_gpio: assert property (@(posedge clock) disable iff (!resetn)
    (!serial_enable && !spi_enable)
    |=> (port_d_oe == $past(gp_port_d_dir) && port_d_out == $past(gp_port_d_out)))
    else $error("Port D not general purpose.");
  chk_serial_rx: assert property (@(posedge clock) disable iff (!resetn)
    serial_enable |=> !port_d_oe[0])
    else $error("Receive pin driven.");
  chk_spi_master: assert property (@(posedge clock) disable iff (!resetn)
    (spi_enable && spi_master)
    |=> (port_d_oe[3] && port_d_oe[4] && !port_d_oe[2]))
    else $error("Master pin directions wrong.");
endmodule : pmx_port_mux

// file: rtl/pmx_params.svh
// Constants for the port mode pin multiplexer.
//------------------------------------------------------------
// Contract
//------------------------------------------------------------
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH
// Mode pin patterns as {high, low}.
`define PMX_PAT_SINGLE 2'h2
`define PMX_PAT_EXPANDED 2'h3
`define PMX_PAT_BOOT 2'h0
`define PMX_PAT_TEST 2'h1
// Port D bit positions.
`define PMX_PD_RXD 0
`define PMX_PD_TXD 1
`define PMX_PD_MISO 2
`define PMX_PD_MOSI 3
`define PMX_PD_SCK 4
`define PMX_PD_SS 5
// Reset value of the latched port C byte.
`define PMX_LATCH_RST 8'h00
`endif

// file: rtl/pmx_pkg.sv
// Types shared by the port mode pin multiplexer.
package pmx_pkg;
  // Operating mode decoded from the mode pins.
  typedef enum logic [1:0] {PMX_SINGLE, PMX_EXPANDED, PMX_BOOT, PMX_TEST} pmx_mode_t;
endpackage : pmx_pkg

// file: rtl/pmx_edge_det.sv
// Edge detector for the handshake strobe input.
`timescale 1ns/1ns
module pmx_edge_det
(
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Strobe level and chosen polarity.
  input wire logic level_in,
  input wire logic rising_sel,
  // One-cycle pulse on the chosen edge.
  output logic edge_pulse
);
  logic prev_q; // Level seen at the previous edge.
  logic armed_q; // Low for the first edge after reset.

  // The previous level, plus a flag that blocks the first edge after reset.
  // The strobe's idle level is not known, so a pin already high or low at release must not read as an edge.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_q <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      prev_q <= level_in;
      armed_q <= 1'b1;
    end
  end

  // Selected transition, only once a real previous level is held.
  assign edge_pulse = armed_q & (rising_sel ? (level_in & ~prev_q) : (~level_in & prev_q));
endmodule : pmx_edge_det

// file: verif/pmx_bus_partner.sv
// Behavioural model of an external memory on the expansion bus.
`timescale 1ns/1ns
module pmx_bus_partner
(
  // Clock.
  input wire logic clock,
  // Expansion bus as seen at the pins.
  input wire logic bus_phase_clock,
  input wire logic address_latch_strobe,
  input wire logic bus_direction,
  input wire logic [7:0] high_address_lines,
  input wire logic [7:0] port_c_lines,
  // A slow answer holds read data back for one data cycle.
  input wire logic slow,
  // Level this device puts on the port C lines.
  output logic [7:0] drive_data
);
  //----------------------------------------------------------
  // Storage and bus tracking
  //----------------------------------------------------------
  logic [7:0] mem_q [0:65535]; // Memory over the whole 64 Kbyte space.
  logic [7:0] addr_lo_q = 8'h00; // Low address held after the strobe falls.
  logic [7:0] last_q = 8'h5A; // Last level put on the lines.
  logic wait_q = 1'b0; // Set once a read data phase has lasted a cycle.
  logic drive_en;
  logic [15:0] addr;
  // The low byte is live while the strobe is high, latched after it.
  assign addr = {high_address_lines, address_latch_strobe ? port_c_lines : addr_lo_q};
  // Data is driven only in the read data phase; otherwise the lines toggle so a stale value never matches.
  assign drive_en = bus_phase_clock & bus_direction & (!slow | wait_q);
  assign drive_data = drive_en ? mem_q[addr] : ~last_q;
  // Capture the address on the strobe and write data in the write data phase.
  always @(posedge clock)
  begin
    if (address_latch_strobe)
      addr_lo_q <= port_c_lines;
    if (bus_phase_clock && !bus_direction && !address_latch_strobe)
      mem_q[addr] <= port_c_lines;
    wait_q <= bus_phase_clock & bus_direction;
    last_q <= drive_data;
  end
endmodule : pmx_bus_partner

// file: verif/tb_port_mode_pin_mux.sv
// Self-checking testbench for the port mode pin multiplexer.
`timescale 1ns/1ns
`include "pmx_params.svh"
module tb_port_mode_pin_mux;
  //----------------------------------------------------------
  // Stimulus and observed signals
  //----------------------------------------------------------
  logic clock = 1'b0, resetn = 1'b0, mode_select_low = 1'b0, mode_select_high = 1'b1, bus_phase_clock = 1'b0;
  logic core_read = 1'b0, strobe_rising = 1'b1, handshake_out_level = 1'b0, handshake_strobe_in = 1'b0;
  logic serial_enable = 1'b0, spi_enable = 1'b0, spi_master = 1'b0, serial_transmit_out = 1'b0;
  logic spi_miso_out = 1'b0, spi_mosi_out = 1'b0, spi_sck_out = 1'b0, slow = 1'b0, sc_mode = 1'b1;
  logic [15:0] core_addr = 16'h0000;
  logic [7:0] core_wdata = 8'h00, gp_port_b_out = 8'h00, gp_port_c_out = 8'h00, gp_port_c_dir = 8'h00;
  logic [7:0] port_e_in = 8'h00, tb_ext = 8'h00;
  logic [5:0] gp_port_d_out = 6'h00, gp_port_d_dir = 6'h00, port_d_in = 6'h00;
  logic [7:0] core_rdata, port_c_in_value, port_c_latched, port_b_out, port_c_lines_out, port_c_lines_oe;
  logic [7:0] port_e_value, analog_channel, pc_drive, port_c_lines_in;
  logic latch_event, strobe_b_out, address_latch_strobe, address_latch_strobe_oe, serial_receive_in;
  logic spi_miso_in, spi_mosi_in, spi_sck_in, spi_select_in;
  logic [5:0] port_d_in_value, port_d_out, port_d_oe;
  pmx_pkg::pmx_mode_t mode;
  int bad_count = 0, checks = 0, cycles = 0;
  // The port C wire: whoever enables drives it, the board's own source otherwise.
  assign port_c_lines_in = (port_c_lines_oe & port_c_lines_out) | (~port_c_lines_oe & (sc_mode ? tb_ext : pc_drive));
  initial
  begin
    forever #5 clock = ~clock;
  end
  pmx_port_mux u_dut (.clock, .resetn, .mode_select_low, .mode_select_high, .bus_phase_clock, .core_addr,
    .core_read, .core_wdata, .core_rdata, .gp_port_b_out, .gp_port_c_out, .gp_port_c_dir, .strobe_rising,
    .handshake_out_level, .port_c_in_value, .port_c_latched, .latch_event, .port_b_out, .port_c_lines_in,
    .port_c_lines_out, .port_c_lines_oe, .handshake_strobe_in, .strobe_b_out, .address_latch_strobe,
    .address_latch_strobe_oe, .gp_port_d_out, .gp_port_d_dir, .port_d_in_value, .serial_enable, .spi_enable,
    .spi_master, .serial_transmit_out, .serial_receive_in, .spi_miso_out, .spi_mosi_out, .spi_sck_out,
    .spi_miso_in, .spi_mosi_in, .spi_sck_in, .spi_select_in, .port_d_in, .port_d_out, .port_d_oe, .port_e_in,
    .port_e_value, .analog_channel, .mode);
  pmx_bus_partner u_partner (.clock, .bus_phase_clock, .address_latch_strobe, .bus_direction(strobe_b_out),
    .high_address_lines(port_b_out), .port_c_lines(port_c_lines_in), .slow, .drive_data(pc_drive));
  //----------------------------------------------------------
  // Checking and closing
  //----------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  // A hung wait is cut short well beyond the fewer than one hundred cycles the run needs.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  //----------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------
  // Reset with a pin pattern, then move the pins to show the mode stays frozen.
  task automatic reset_mode(input logic [1:0] pat, input pmx_pkg::pmx_mode_t exp, input logic sc);
    @(posedge clock);
    resetn <= 1'b0;
    mode_select_high <= pat[1];
    mode_select_low <= pat[0];
    sc_mode <= sc;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    mode_select_high <= ~pat[1];
    mode_select_low <= ~pat[0];
    repeat (2) @(posedge clock);
    #1 chk(mode, exp);
    chk(mode, exp);
  endtask : reset_mode
  // One expansion cycle: an address phase, then a data phase of three cycles.
  task automatic bus_cycle(input logic [15:0] a, input logic rd, input logic [7:0] d, input logic slw);
    @(posedge clock);
    bus_phase_clock <= 1'b0;
    core_addr <= a;
    core_read <= rd;
    core_wdata <= d;
    slow <= slw;
    @(posedge clock);
    bus_phase_clock <= 1'b1;
    #1 chk(port_b_out, a[15:8]);
    chk(port_c_lines_out & port_c_lines_oe, a[7:0]);
    chk({address_latch_strobe, address_latch_strobe_oe}, 2'h3);
    chk(strobe_b_out, rd);
    @(posedge clock);
    #1 chk(port_c_lines_oe, rd ? 8'h00 : 8'hFF);
    chk(address_latch_strobe, 1'b0);
    chk(strobe_b_out, rd);
    chk(port_c_lines_in, d);
    @(posedge clock);
    #1 if (rd)
      chk(core_rdata, d);
  endtask : bus_cycle
  // General-purpose port B and C, handshake output and strobe latching.
  task automatic single_chip_io(input logic rise);
    @(posedge clock);
    strobe_rising <= rise;
    gp_port_b_out <= 8'hA5;
    gp_port_c_out <= 8'h3C;
    gp_port_c_dir <= 8'h0F;
    handshake_out_level <= 1'b1;
    tb_ext <= 8'h96;
    repeat (2) @(posedge clock);
    handshake_strobe_in <= 1'b1;
    #1 chk(port_b_out, 8'hA5);
    chk({port_c_lines_oe, port_c_lines_out & port_c_lines_oe}, 16'h0F0C);
    chk(port_c_in_value, 8'h9C);
    chk({strobe_b_out, address_latch_strobe}, 2'h2);
    @(posedge clock);
    #1 chk(latch_event, rise);
    repeat (2) @(posedge clock);
    tb_ext <= 8'h00;
    #1 chk(port_c_latched, rise ? 8'h9C : `PMX_LATCH_RST);
    chk(latch_event, 1'b0);
    repeat (2) @(posedge clock);
    handshake_strobe_in <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk(port_c_latched, rise ? 8'h9C : 8'h0C);
  endtask : single_chip_io
  // Port D as general-purpose lines, then handed to the serial units; port E inputs.
  task automatic port_d_e();
    @(posedge clock);
    gp_port_d_out <= 6'h2A;
    gp_port_d_dir <= 6'h3F;
    port_d_in <= 6'h15;
    port_e_in <= 8'hC3;
    repeat (2) @(posedge clock);
    serial_enable <= 1'b1;
    spi_enable <= 1'b1;
    spi_master <= 1'b1;
    spi_sck_out <= 1'b1;
    port_d_in <= 6'h1E;
    #1 chk({port_d_out, port_d_oe}, 12'hABF);
    chk(port_d_in_value, 6'h15);
    chk({port_e_value, analog_channel}, 16'hC3C3);
    repeat (2) @(posedge clock);
    #1 chk({port_d_out[1], port_d_oe[1]}, 2'h1);
    chk(serial_receive_in, 1'b0);
    chk({port_d_out[4], port_d_out[3]}, 2'h2);
    chk({spi_miso_in, spi_select_in}, 2'h2);
    chk({spi_mosi_in, spi_sck_in}, 2'h3);
  endtask : port_d_e
  //----------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    single_chip_io(1'b1);
    port_d_e();
    reset_mode(2'h3, pmx_pkg::PMX_EXPANDED, 1'b0);
    bus_cycle(16'h1234, 1'b0, 8'h5A, 1'b0);
    bus_cycle(16'hFFFF, 1'b0, 8'hC3, 1'b0);
    bus_cycle(16'h1234, 1'b1, 8'h5A, 1'b0);
    bus_cycle(16'hFFFF, 1'b1, 8'hC3, 1'b1);
    reset_mode(2'h0, pmx_pkg::PMX_BOOT, 1'b1);
    single_chip_io(1'b0);
    reset_mode(2'h1, pmx_pkg::PMX_TEST, 1'b0);
    bus_cycle(16'hBFC0, 1'b0, 8'h77, 1'b0);
    bus_cycle(16'hBFC0, 1'b1, 8'h77, 1'b1);
    reset_mode(2'h2, pmx_pkg::PMX_SINGLE, 1'b1);
    report_and_stop();
  end
endmodule : tb_port_mode_pin_mux
